/* File: hw/hmvwf_filter.sv */
// The address-and-strobe port was chosen for this implementation.
`timescale 1ns/1ps
module hmvwf_filter
#(
  parameter int ADDR_W = 8                    // register address width
)
(
  input  wire logic                 core_clk,     // 250 MHz system clock
  input  wire logic                 rst_b,        // synchronous reset, active low
  input  wire logic                 soft_rst,     // digital/soft reset pulse
  input  wire logic [ADDR_W-1:0]    reg_addr,     // register address
  input  wire logic [31:0]          reg_wdata,    // write data
  input  wire logic                 reg_wr,       // write strobe
  input  wire logic                 reg_rd,       // read strobe
  output logic [31:0]               reg_rdata,    // read data, cycle after strobe
  input  wire hmvwf_pkg::hmvwf_rx_s rx,           // received byte stream
  input  wire logic [47:0]          station_mac,  // own address, byte 0 in [7:0]
  output hmvwf_pkg::hmvwf_stat_s    frame_stat,   // per-frame verdict
  output logic                      wake_req,     // one-cycle wake request
  output logic                      irq           // level interrupt
);

  // address decode
  wire wr_tag1  = reg_wr && (reg_addr == ADDR_W'(hmvwf_pkg::OFS_TAG1));
  wire wr_tag2  = reg_wr && (reg_addr == ADDR_W'(hmvwf_pkg::OFS_TAG2));
  wire wr_load  = reg_wr && (reg_addr == ADDR_W'(hmvwf_pkg::OFS_WF_LOAD));
  wire wr_wcs   = reg_wr && (reg_addr == ADDR_W'(hmvwf_pkg::OFS_WAKE_CS));
  wire wr_mask  = reg_wr && (reg_addr == ADDR_W'(hmvwf_pkg::OFS_IRQ_MASK));

  // register state
  logic [15:0] tag1_q;                     // first tag identifier
  logic [15:0] tag2_q;                     // second tag identifier
  logic [31:0] wcs_q;                      // wake control and flags
  logic [31:0] wcs_d;
  logic [31:0] mask_q;                     // interrupt mask
  logic [31:0] rdata_q;                    // read data register
  logic [31:0] rd_mux;
  logic [31:0] wf_mem_q [hmvwf_pkg::WF_WORDS]; // filter dwords
  logic [2:0]  wf_idx_q;                   // filter load index

  // frame tracking
  logic [11:0] byte_cnt_q;                 // index of next byte
  logic [7:0]  tag_hi_q;                   // 13th byte held
  logic        vlan1_q;                    // first tag seen
  logic        vlan2_q;                    // second tag seen
  logic        ucast_q;                    // destination is unicast
  hmvwf_pkg::hmvwf_stat_s stat_q;          // verdict register
  logic        wake_q;                     // wake request register

  // magic hunter state
  hmvwf_pkg::hmvwf_mp_e mp_st_q, mp_st_d;
  logic [2:0]  ff_run_q, ff_run_d;         // run of fill bytes
  logic [2:0]  mp_idx_q, mp_idx_d;         // byte within address copy
  logic [3:0]  mp_rep_q, mp_rep_d;         // address copies matched
  logic        mp_seen_q, mp_seen_d;       // full pattern found

  // current byte position, restarts at start of frame
  wire [11:0] cur_idx   = rx.sof ? 12'h000 : byte_cnt_q;
  wire [11:0] frame_len = cur_idx + 12'h001;
  wire [15:0] type_word = {tag_hi_q, rx.data};
  wire        at_tag    = rx.valid && (cur_idx == hmvwf_pkg::TAG_LO_IDX);
  wire        hit1      = at_tag && (type_word == tag1_q);                // [R2]
  wire        hit2      = at_tag && (type_word == tag2_q) && !hit1;      // [R3] [R5]

  // legal length by tag class; first tag checked first
  wire [11:0] max_len = vlan1_q ? hmvwf_pkg::LEN_TAG1 :                  // [R1] [R5]
                        vlan2_q ? hmvwf_pkg::LEN_TAG2 :                  // [R4]
                                  hmvwf_pkg::LEN_NORMAL;
  wire        too_long  = frame_len > max_len;
  wire        frame_end = rx.valid && rx.eof;
  wire        frame_ok  = frame_end && !rx.err && !too_long;

  // crc-16 of one byte, msb first
  function automatic logic [15:0] crc16_byte(input logic [15:0] c, input logic [7:0] b);
    logic [15:0] r;
    r = c;
    for (int i = 7; i >= 0; i--)
    begin
      if (r[15] ^ b[i])
        r = {r[14:0], 1'b0} ^ hmvwf_pkg::CRC_POLY;
      else
        r = {r[14:0], 1'b0};
    end
    return r;
  endfunction

  // one crc engine per filter; bytes chosen by the byte mask
  logic [hmvwf_pkg::WF_FILTERS-1:0] filt_hit;
  for (genvar f = 0; f < hmvwf_pkg::WF_FILTERS; f++)
  begin : g_filt
    logic [15:0] crc_q;                    // running crc
    wire  [7:0]  ofs   = wf_mem_q[hmvwf_pkg::WF_OFS_WORD][f*8 +: 8];
    wire  [11:0] rel   = cur_idx - {4'h0, ofs};
    wire         inwin = (cur_idx >= {4'h0, ofs}) && (rel < hmvwf_pkg::WF_SPAN);
    wire         take  = rx.valid && inwin && wf_mem_q[f][rel[4:0]];
    wire  [15:0] base  = rx.sof ? hmvwf_pkg::CRC_INIT : crc_q;
    wire  [15:0] crc_d = take ? crc16_byte(base, rx.data) : base;
    wire  [15:0] ref_c = wf_mem_q[hmvwf_pkg::WF_CRC_WORD + f/2][(f%2)*16 +: 16];
    // compare including the last byte of the frame
    assign filt_hit[f] = wf_mem_q[hmvwf_pkg::WF_CMD_WORD][f*8] && (crc_d == ref_c);
    // crc register
    always_ff @(posedge core_clk)
    begin
      if (!rst_b)
        crc_q <= hmvwf_pkg::CRC_INIT;
      else if (rx.valid)
        crc_q <= crc_d;
    end
  end

  // magic packet hunter: six fill bytes then sixteen address copies
  // expected byte comes from the registered index, so no loop through the case below
  wire [7:0] mac_byte = station_mac[mp_idx_q*8 +: 8];
  always_comb
  begin
    mp_st_d   = rx.sof ? hmvwf_pkg::MP_HUNT : mp_st_q;
    ff_run_d  = rx.sof ? 3'h0 : ff_run_q;
    mp_idx_d  = mp_idx_q;
    mp_rep_d  = mp_rep_q;
    mp_seen_d = rx.sof ? 1'b0 : mp_seen_q;
    if (rx.valid)
    begin
      case (mp_st_d)
        hmvwf_pkg::MP_HUNT:
        begin
          mp_idx_d = 3'h0;
          if (rx.data == hmvwf_pkg::MP_FILL)
          begin
            // extra fill bytes keep the sync
            if (ff_run_d != hmvwf_pkg::MP_SYNC)
              ff_run_d = ff_run_d + 3'h1;
          end
          else if ((ff_run_d == hmvwf_pkg::MP_SYNC) && (rx.data == station_mac[7:0]))
          begin
            mp_st_d  = hmvwf_pkg::MP_MATCH;
            mp_idx_d = 3'h1;
            mp_rep_d = 4'h0;
            ff_run_d = 3'h0;
          end
          else
            ff_run_d = 3'h0;
        end
        hmvwf_pkg::MP_MATCH:
        begin
          if (rx.data == mac_byte)
          begin
            if (mp_idx_q == hmvwf_pkg::MP_LAST_BYTE)
            begin
              mp_idx_d = 3'h0;
              if (mp_rep_q == hmvwf_pkg::MP_LAST_REP)
              begin
                mp_seen_d = 1'b1;
                mp_st_d   = hmvwf_pkg::MP_HUNT;
              end
              else
                mp_rep_d = mp_rep_q + 4'h1;
            end
            else
              mp_idx_d = mp_idx_q + 3'h1;
          end
          else
          begin
            // a broken copy may itself start a new sync run
            mp_st_d  = hmvwf_pkg::MP_HUNT;
            ff_run_d = (rx.data == hmvwf_pkg::MP_FILL) ? 3'h1 : 3'h0;
          end
        end
        default:
          mp_st_d = hmvwf_pkg::MP_HUNT;
      endcase
    end
  end

  // wake events, only on clean frames inside the legal length
  wire mpr_set = frame_ok && wcs_q[hmvwf_pkg::MAGIC_PACKET_DETECT_ENABLE_POS] && mp_seen_d;      // [R14] [R16]
  wire wfr_set = frame_ok && wcs_q[hmvwf_pkg::WEN_POS] && (|filt_hit);     // [R13] [R15]
  wire gu_set  = frame_ok && wcs_q[hmvwf_pkg::GUE_POS] && ucast_q;         // [R11]
  wire [31:0] flag_set = (mpr_set ? hmvwf_pkg::MPR_BIT : 32'h0000_0000) |
                         (wfr_set ? hmvwf_pkg::WFR_BIT : 32'h0000_0000);
  wire [31:0] flag_clr = wr_wcs ? (reg_wdata & hmvwf_pkg::FLAG_MASK) : 32'h0000_0000;

  // flags: write one clears, a set in the same cycle wins
  assign wcs_d = ((wcs_q & hmvwf_pkg::FLAG_MASK & ~flag_clr) | flag_set) |   // [R17]
                 (wr_wcs ? (reg_wdata & hmvwf_pkg::CTL_MASK) : (wcs_q & hmvwf_pkg::CTL_MASK));

  // read decode; the filter port and unmapped offsets read zero
  always_comb
  begin
    if (reg_addr == ADDR_W'(hmvwf_pkg::OFS_TAG1))
      rd_mux = {16'h0000, tag1_q};
    else if (reg_addr == ADDR_W'(hmvwf_pkg::OFS_TAG2))
      rd_mux = {16'h0000, tag2_q};
    else if (reg_addr == ADDR_W'(hmvwf_pkg::OFS_WAKE_CS))
      rd_mux = wcs_q;
    else if (reg_addr == ADDR_W'(hmvwf_pkg::OFS_IRQ_MASK))
      rd_mux = mask_q;
    else
      rd_mux = hmvwf_pkg::WORD_RESET;                                      // [R10] [R18]
  end

  // software registers
  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      tag1_q  <= hmvwf_pkg::TAG_RESET;
      tag2_q  <= hmvwf_pkg::TAG_RESET;
      wcs_q   <= hmvwf_pkg::WORD_RESET;
      mask_q  <= hmvwf_pkg::WORD_RESET;
      rdata_q <= hmvwf_pkg::WORD_RESET;
    end
    else
    begin
      tag1_q  <= wr_tag1 ? reg_wdata[15:0] : tag1_q;
      tag2_q  <= wr_tag2 ? reg_wdata[15:0] : tag2_q;
      wcs_q   <= wcs_d;
      mask_q  <= wr_mask ? (reg_wdata & hmvwf_pkg::FLAG_MASK) : mask_q;
      // data stands for one cycle only
      rdata_q <= reg_rd ? rd_mux : hmvwf_pkg::WORD_RESET;
    end
  end

  // filter load index; reads never move it
  always_ff @(posedge core_clk)
  begin
    if (!rst_b || soft_rst)
      wf_idx_q <= 3'h0;                                                    // [R9]
    else if (wr_load)
      wf_idx_q <= wf_idx_q + 3'h1;                                         // [R8]
  end

  // filter storage, not reset: contents are undefined until loaded
  always_ff @(posedge core_clk)
  begin
    if (wr_load)
      wf_mem_q[wf_idx_q] <= reg_wdata;                                     // [R7]
  end

  // per-frame tracking
  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      byte_cnt_q <= 12'h000;
      tag_hi_q   <= 8'h00;
      vlan1_q    <= 1'b0;
      vlan2_q    <= 1'b0;
      ucast_q    <= 1'b0;
    end
    else if (rx.valid)
    begin
      // saturate so huge frames stay too long
      byte_cnt_q <= (cur_idx == hmvwf_pkg::IDX_SAT) ? cur_idx : cur_idx + 12'h001;
      tag_hi_q   <= (cur_idx == hmvwf_pkg::TAG_HI_IDX) ? rx.data : tag_hi_q;
      vlan1_q    <= hit1 || (!rx.sof && vlan1_q);
      vlan2_q    <= hit2 || (!rx.sof && vlan2_q);
      ucast_q    <= rx.sof ? !rx.data[0] : ucast_q;                        // [R12]
    end
  end

  // magic hunter registers
  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      mp_st_q   <= hmvwf_pkg::MP_HUNT;
      ff_run_q  <= 3'h0;
      mp_idx_q  <= 3'h0;
      mp_rep_q  <= 4'h0;
      mp_seen_q <= 1'b0;
    end
    else
    begin
      mp_st_q   <= mp_st_d;
      ff_run_q  <= ff_run_d;
      mp_idx_q  <= mp_idx_d;
      mp_rep_q  <= mp_rep_d;
      mp_seen_q <= mp_seen_d;
    end
  end

  // verdict and wake request registers
  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      stat_q <= '0;
      wake_q <= 1'b0;
    end
    else
    begin
      stat_q.done     <= frame_end;
      stat_q.too_long <= frame_end && too_long;
      stat_q.tag1     <= vlan1_q;
      stat_q.tag2     <= vlan2_q;
      stat_q.len      <= frame_end ? frame_len : stat_q.len;
      wake_q          <= mpr_set || wfr_set || gu_set;                     // [R11]
    end
  end

  assign reg_rdata  = rdata_q;
  assign frame_stat = stat_q;
  assign wake_req   = wake_q;
  // level interrupt from unmasked sticky flags
  assign irq        = |(wcs_q & mask_q);

  // checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);

  sequence load_word_s;
    wr_load && !soft_rst;
  endsequence

  tag1_detect_a: assert property (hit1 |=> vlan1_q && !vlan2_q) // [R2]
    else $error("first tag match not recorded");
  tag2_detect_a: assert property (at_tag && (type_word == tag2_q) // [R3] [R5]
    |=> (vlan2_q == ($past(type_word) != $past(tag1_q))))
    else $error("second tag class wrong");
  tag1_len_a: assert property (frame_end && vlan1_q && !rx.err // [R1]
    && (frame_len == hmvwf_pkg::LEN_TAG1) |=> stat_q.done && !stat_q.too_long)
    else $error("1522 byte tagged frame refused");
  tag1_over_a: assert property (frame_end && vlan1_q // [R5]
    && (frame_len == hmvwf_pkg::LEN_TAG1 + 12'h001) |=> stat_q.too_long)
    else $error("first tag frame over 1522 accepted");
  tag2_len_a: assert property (frame_end && vlan2_q && !vlan1_q // [R4]
    && (frame_len == hmvwf_pkg::LEN_TAG2) |=> !stat_q.too_long ##1 !stat_q.too_long)
    else $error("1538 byte tagged frame refused");
  filter_load_a: assert property (load_word_s |=> // [R7] [R8]
    (wf_mem_q[$past(wf_idx_q)] == $past(reg_wdata)) && (wf_idx_q == $past(wf_idx_q) + 3'h1))
    else $error("filter dword not loaded in order");
  index_reset_a: assert property (soft_rst |=> wf_idx_q == 3'h0) // [R9]
    else $error("filter index not reset");
  port_read_a: assert property (reg_rd && (reg_addr == ADDR_W'(hmvwf_pkg::OFS_WF_LOAD)) // [R10] [R18]
    |=> (reg_rdata == 32'h0000_0000) && $stable(wf_idx_q))
    else $error("filter port read not zero");
  flag_sticky_a: assert property (wcs_q[hmvwf_pkg::MPR_POS] // [R17]
    && !(wr_wcs && reg_wdata[hmvwf_pkg::MPR_POS]) |=> wcs_q[hmvwf_pkg::MPR_POS])
    else $error("magic flag lost without clear");
  magic_off_a: assert property (!wcs_q[hmvwf_pkg::MAGIC_PACKET_DETECT_ENABLE_POS] && !wcs_q[hmvwf_pkg::MPR_POS] // [R16]
    |=> !wcs_q[hmvwf_pkg::MPR_POS])
    else $error("magic flag set while disabled");
  magic_set_a: assert property (frame_ok && mp_seen_d && wcs_q[hmvwf_pkg::MAGIC_PACKET_DETECT_ENABLE_POS] // [R14]
    |=> wcs_q[hmvwf_pkg::MPR_POS] && wake_req)
    else $error("magic packet not flagged");
  wake_frame_a: assert property (frame_ok && (|filt_hit) && wcs_q[hmvwf_pkg::WEN_POS] // [R13] [R15]
    |=> wcs_q[hmvwf_pkg::WFR_POS] && wake_req)
    else $error("wake frame not flagged");
  unicast_mark_a: assert property (rx.valid && rx.sof // [R12]
    |=> ucast_q == !$past(rx.data[0]))
    else $error("unicast class not taken from first byte");
  unicast_wake_a: assert property (frame_ok && wcs_q[hmvwf_pkg::GUE_POS] && ucast_q // [R11]
    |=> wake_req)
    else $error("global unicast did not wake");

endmodule

/* File: include/hmvwf_pkg.sv */
// How it works
// (R1) first tag frame: legal length 1522 bytes
// (R2) first tag compared with bytes 13 and 14
// (R3) second tag compared with bytes 13 and 14
// (R4) second tag frame: legal length 1538 bytes
// (R5) equal tags: first tag wins, 1522 limit
// (R6) software keeps tags distinct, typically 8100h
// (R7) each filter port write fills next dword
// (R8) index wraps to dword 0 after eight
// (R9) any reset returns filter index to zero
// (R10) filter port is write-only
// (R11) unicast wake enable wakes on global unicast
// (R12) global unicast: destination bit 0 is zero
// (R13) matching wake frame sets received flag bit 6
// (R14) valid magic packet sets flag bit 5
// (R15) wake frame detection only while bit 2 set
// (R16) magic detection only while bit 1 set
// (R17) flags stay set until written with one
// (R18) filter port reads zero, changes nothing
package hmvwf_pkg;
  // register offsets on the plain register port
  localparam logic [7:0]  OFS_TAG1      = 8'h09;
  localparam logic [7:0]  OFS_TAG2      = 8'h0a;
  localparam logic [7:0]  OFS_WF_LOAD   = 8'h0b;
  localparam logic [7:0]  OFS_WAKE_CS   = 8'h0c;
  localparam logic [7:0]  OFS_IRQ_MASK  = 8'h0d;
  // reset values
  localparam logic [15:0] TAG_RESET     = 16'hffff;
  localparam logic [31:0] WORD_RESET    = 32'h0000_0000;
  // wake control/status field layout
  localparam logic [31:0] GUE_BIT       = 32'h0000_0200;
  localparam logic [31:0] WFR_BIT       = 32'h0000_0040;
  localparam logic [31:0] MPR_BIT       = 32'h0000_0020;
  localparam logic [31:0] WEN_BIT       = 32'h0000_0004;
  localparam logic [31:0] MAGIC_PACKET_DETECT_ENABLE_BIT      = 32'h0000_0002;
  localparam logic [31:0] CTL_MASK      = 32'h0000_0206;
  localparam logic [31:0] FLAG_MASK     = 32'h0000_0060;
  localparam int          GUE_POS       = 9;
  localparam int          WFR_POS       = 6;
  localparam int          MPR_POS       = 5;
  localparam int          WEN_POS       = 2;
  localparam int          MAGIC_PACKET_DETECT_ENABLE_POS      = 1;
  // legal frame lengths in bytes; byte index saturation
  localparam logic [11:0] LEN_NORMAL    = 12'h05ee;
  localparam logic [11:0] LEN_TAG1      = 12'h05f2;
  localparam logic [11:0] LEN_TAG2      = 12'h0602;
  localparam logic [11:0] IDX_SAT       = 12'h0ffe;
  // zero-based positions of the 13th and 14th bytes
  localparam logic [11:0] TAG_HI_IDX    = 12'h000c;
  localparam logic [11:0] TAG_LO_IDX    = 12'h000d;
  // wake-up filter layout
  localparam int          WF_WORDS      = 8;
  localparam int          WF_FILTERS    = 4;
  localparam int          WF_CMD_WORD   = 4;
  localparam int          WF_OFS_WORD   = 5;
  localparam int          WF_CRC_WORD   = 6;
  localparam logic [11:0] WF_SPAN       = 12'h0020;
  localparam logic [15:0] CRC_INIT      = 16'hffff;
  localparam logic [15:0] CRC_POLY      = 16'h8005;
  // magic packet pattern
  localparam logic [2:0]  MP_SYNC       = 3'h6;
  localparam logic [2:0]  MP_LAST_BYTE  = 3'h5;
  localparam logic [3:0]  MP_LAST_REP   = 4'hf;
  localparam logic [7:0]  MP_FILL       = 8'hff;

  // magic packet hunter states
  typedef enum logic [1:0] {
    MP_HUNT  = 2'b01,
    MP_MATCH = 2'b10
  } hmvwf_mp_e;

  // one received byte from the fabric
  typedef struct packed {
    logic       valid;
    logic       sof;
    logic       eof;
    logic       err;
    logic [7:0] data;
  } hmvwf_rx_s;

  // per-frame verdict
  typedef struct packed {
    logic        done;
    logic        too_long;
    logic        tag1;
    logic        tag2;
    logic [11:0] len;
  } hmvwf_stat_s;
endpackage

/* File: verif/hmvwf_fabric_model.sv */
`timescale 1ns/1ps
// frame source standing in for the switch fabric
module hmvwf_fabric_model
(
  input  wire logic            core_clk,     // system clock
  input  wire logic [47:0]     station_mac,  // own address, used for magic copies
  output hmvwf_pkg::hmvwf_rx_s rx            // byte stream towards the mac
);
  logic       slow;    // idle beat before every third byte
  logic [7:0] last_b;  // last byte sent; idle beats show its inverse

  // quiet link at time zero
  initial
  begin
    slow   = 1'b0;
    last_b = 8'h00;
    rx     = '0;
  end

  // byte i of a generated frame: address, tag, optional magic, filler
  function automatic logic [7:0] byte_at(input int i, input logic [7:0] da0,
                                         input logic [15:0] tag, input logic magic);
    if (i == 0)
      return da0;
    if (i == 12)
      return tag[15:8];
    if (i == 13)
      return tag[7:0];
    if (magic && i >= 14 && i < 20)
      return 8'hff;
    if (magic && i >= 20 && i < 116)
      return station_mac[8*((i-20)%6) +: 8];
    return i[7:0] ^ 8'h5a;
  endfunction

  // one frame of n bytes; idle beats never repeat stale data
  task automatic send(input logic [7:0] da0, input logic [15:0] tag, input int n,
                      input logic magic, input logic err_f);
    logic [7:0] b;
    for (int i = 0; i < n; i++)
    begin
      if (slow && i % 3 == 2)
      begin
        @(posedge core_clk);
        rx <= '{1'b0, 1'b0, 1'b0, 1'b0, ~last_b};
      end
      b = byte_at(i, da0, tag, magic);
      @(posedge core_clk);
      rx <= '{1'b1, i == 0, i == n - 1, err_f && i == n - 1, b};
      last_b = b;
    end
    @(posedge core_clk);
    rx <= '{1'b0, 1'b0, 1'b0, 1'b0, ~last_b};
  endtask
endmodule

/* File: verif/host_mac_vlan_wakeup_filter_tb.sv */
`timescale 1ns/1ps
`define CHK(g, e) \
  begin \
    total_checks++; \
    if ((g) !== (e)) \
    begin \
      fails++; \
      $display("[FAIL] t=%0t got=%0h exp=%0h", $time, (g), (e)); \
    end \
  end
module host_mac_vlan_wakeup_filter_tb;
  localparam logic [47:0] MAC = 48'h0b0a_0908_0706;  // station address
  logic        core_clk;     // system clock
  logic        rst_b;        // reset, active low
  logic        soft_rst;     // filter index reset pulse
  logic [7:0]  reg_addr;     // register address
  logic [31:0] reg_wdata;    // write data
  logic        reg_wr;       // write strobe
  logic        reg_rd;       // read strobe
  logic [31:0] reg_rdata;    // read data
  logic        wake_req;     // wake pulse
  logic        irq;          // interrupt level
  int          fails;        // mismatches
  int          total_checks; // comparisons made
  int          done_cnt;     // verdicts seen
  int          wake_cnt;     // wake pulses seen
  logic [31:0] fw [8];       // filter load words
  hmvwf_pkg::hmvwf_rx_s   rx;         // byte stream
  hmvwf_pkg::hmvwf_stat_s frame_stat; // frame verdict
  hmvwf_pkg::hmvwf_stat_s last_stat;  // verdict of the latest frame
  int          n_a [7] = '{1518, 1519, 1522, 1523, 1538, 1539, 1523};  // frame sizes
  logic [15:0] tg_a [7] = '{16'h0800, 16'h0800, 16'h8100, 16'h8100,
                            16'h88a8, 16'h88a8, 16'h8100};           // type bytes
  logic        tl_a [7] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b1};  // too long

  hmvwf_filter #(.ADDR_W(8)) u_dut (.core_clk(core_clk), .rst_b(rst_b), .soft_rst(soft_rst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .rx(rx), .station_mac(MAC), .frame_stat(frame_stat),
    .wake_req(wake_req), .irq(irq));
  hmvwf_fabric_model u_fab (.core_clk(core_clk), .station_mac(MAC), .rx(rx));

  // free-running clock, 4 ns period
  initial
  begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end

  // count verdicts and wake pulses; pulses last one cycle only
  always @(posedge core_clk)
  begin
    if (frame_stat.done === 1'b1)
    begin
      done_cnt <= done_cnt + 1;
      last_stat <= frame_stat;
    end
    if (wake_req === 1'b1)
      wake_cnt <= wake_cnt + 1;
  end

  // one-cycle write strobe
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask

  // read; data stands only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 `CHK(reg_rdata, e)
  endtask

  // send a frame and let its verdict land
  task automatic frame(input logic [7:0] da0, input logic [15:0] tag, input int n,
                       input logic magic, input logic err_f);
    u_fab.send(da0, tag, n, magic, err_f);
    repeat (4) @(posedge core_clk);
  endtask

  // msb-first checksum of one byte, own copy of the algorithm
  function automatic logic [15:0] crc16(input logic [7:0] d);
    logic [15:0] c;
    c = 16'hffff;
    for (int b = 7; b >= 0; b--)
      c = (c[15] ^ d[b]) ? {c[14:0], 1'b0} ^ 16'h8005 : {c[14:0], 1'b0};
    return c;
  endfunction

  task automatic test_done();
    if (fails == 0 && total_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // hang guard, well beyond the expected run
  initial
  begin
    repeat (60000) @(posedge core_clk);
    fails++;
    test_done();
  end

  initial
  begin
    {rst_b, soft_rst, reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
    {fails, total_checks, done_cnt, wake_cnt} = '0;
    last_stat = '0;
    // filter 0: one byte at offset 20, enabled, checksum of that byte
    fw = '{32'h0000_0001, 32'h0, 32'h0, 32'h0, 32'h0000_0001, 32'h0000_0014,
           {16'h0000, crc16(8'd20 ^ 8'h5a)}, 32'h0};
    repeat (12) @(posedge core_clk);
    rst_b <= 1'b1;
    rd(hmvwf_pkg::OFS_TAG1, 32'h0000_ffff);
    rd(hmvwf_pkg::OFS_TAG2, 32'h0000_ffff);
    rd(hmvwf_pkg::OFS_WAKE_CS, 32'h0);
    rd(8'h00, 32'h0);  // unmapped offset
    rd(hmvwf_pkg::OFS_WF_LOAD, 32'h0);
    wr(hmvwf_pkg::OFS_TAG1, 32'hdead_8100);
    wr(hmvwf_pkg::OFS_TAG2, 32'h0000_88a8);
    rd(hmvwf_pkg::OFS_TAG1, 32'h0000_8100);
    // legal length at each limit, plain and tagged; last one with equal tags
    for (int k = 0; k < 7; k++)
    begin
      if (k == 6)
        wr(hmvwf_pkg::OFS_TAG2, 32'h0000_8100);
      u_fab.slow = k[0];
      frame(8'h01, tg_a[k], n_a[k], 1'b0, 1'b0);
      `CHK(last_stat.too_long, tl_a[k])
      `CHK(last_stat.tag1, tg_a[k] == 16'h8100)
      `CHK(last_stat.len, n_a[k][11:0])
      `CHK(last_stat.tag2, tg_a[k] == 16'h88a8)
    end
    `CHK(done_cnt, 7)
    u_fab.slow = 1'b0;
    // magic packet: disabled, errored, then good; sticky flag and interrupt
    wr(hmvwf_pkg::OFS_IRQ_MASK, hmvwf_pkg::FLAG_MASK);
    frame(8'h01, 16'h0800, 128, 1'b1, 1'b0);
    rd(hmvwf_pkg::OFS_WAKE_CS, 32'h0);
    wr(hmvwf_pkg::OFS_WAKE_CS, hmvwf_pkg::MAGIC_PACKET_DETECT_ENABLE_BIT);
    frame(8'h01, 16'h0800, 128, 1'b1, 1'b1);
    rd(hmvwf_pkg::OFS_WAKE_CS, hmvwf_pkg::MAGIC_PACKET_DETECT_ENABLE_BIT);
    `CHK(wake_cnt, 0)
    frame(8'h01, 16'h0800, 128, 1'b1, 1'b0);
    rd(hmvwf_pkg::OFS_WAKE_CS, hmvwf_pkg::MAGIC_PACKET_DETECT_ENABLE_BIT | hmvwf_pkg::MPR_BIT);
    `CHK(wake_cnt, 1)
    `CHK(irq, 1'b1)
    wr(hmvwf_pkg::OFS_IRQ_MASK, 32'h0);
    #1 `CHK(irq, 1'b0)  // masked source stays quiet
    wr(hmvwf_pkg::OFS_IRQ_MASK, hmvwf_pkg::FLAG_MASK);
    wr(hmvwf_pkg::OFS_WAKE_CS, hmvwf_pkg::MAGIC_PACKET_DETECT_ENABLE_BIT);
    rd(hmvwf_pkg::OFS_WAKE_CS, hmvwf_pkg::MAGIC_PACKET_DETECT_ENABLE_BIT | hmvwf_pkg::MPR_BIT);
    wr(hmvwf_pkg::OFS_WAKE_CS, hmvwf_pkg::MPR_BIT);
    rd(hmvwf_pkg::OFS_WAKE_CS, 32'h0);
    `CHK(irq, 1'b0)
    // global unicast: only address bit 0 clear with the enable set
    wr(hmvwf_pkg::OFS_WAKE_CS, hmvwf_pkg::GUE_BIT);
    rd(hmvwf_pkg::OFS_WAKE_CS, hmvwf_pkg::GUE_BIT);
    frame(8'h02, 16'h0800, 64, 1'b0, 1'b0);
    `CHK(wake_cnt, 2)
    frame(8'h03, 16'h0800, 64, 1'b0, 1'b0);
    `CHK(wake_cnt, 2)
    wr(hmvwf_pkg::OFS_WAKE_CS, 32'h0);
    frame(8'h02, 16'h0800, 64, 1'b0, 1'b0);
    `CHK(wake_cnt, 2)
    // filter load with a read in the middle that must not move the index
    for (int j = 0; j < 8; j++)
    begin
      wr(hmvwf_pkg::OFS_WF_LOAD, fw[j]);
      if (j == 3)
        rd(hmvwf_pkg::OFS_WF_LOAD, 32'h0);
    end
    frame(8'h01, 16'h0800, 64, 1'b0, 1'b0);
    rd(hmvwf_pkg::OFS_WAKE_CS, 32'h0);
    wr(hmvwf_pkg::OFS_WAKE_CS, hmvwf_pkg::WEN_BIT);
    frame(8'h01, 16'h0800, 64, 1'b0, 1'b0);
    rd(hmvwf_pkg::OFS_WAKE_CS, hmvwf_pkg::WEN_BIT | hmvwf_pkg::WFR_BIT);
    `CHK(wake_cnt, 3)
    wr(hmvwf_pkg::OFS_WAKE_CS, hmvwf_pkg::WEN_BIT | hmvwf_pkg::WFR_BIT);
    // ninth write wraps onto the first mask and spoils the match
    wr(hmvwf_pkg::OFS_WF_LOAD, 32'h0);
    frame(8'h01, 16'h0800, 64, 1'b0, 1'b0);
    rd(hmvwf_pkg::OFS_WAKE_CS, hmvwf_pkg::WEN_BIT);
    // soft reset brings the index home, so the mask is restored
    @(posedge core_clk);
    soft_rst <= 1'b1;
    @(posedge core_clk);
    soft_rst <= 1'b0;
    wr(hmvwf_pkg::OFS_WF_LOAD, fw[0]);
    frame(8'h01, 16'h0800, 64, 1'b0, 1'b0);
    rd(hmvwf_pkg::OFS_WAKE_CS, hmvwf_pkg::WEN_BIT | hmvwf_pkg::WFR_BIT);
    test_done();
  end
endmodule
